// ===== casb_pkg.sv
// Purpose: shared constants and types for the execution subset core
// Assumes: 16-bit data path, 24-bit instruction words
// Notes: byte offsets on a 32-bit Avalon-MM word map
package casb_pkg;
    localparam logic [15:0] OFF_INSTR = 16'h0000;
    localparam logic [15:0] OFF_STATUS = 16'h0004;
    localparam logic [15:0] OFF_PC = 16'h0008;
    localparam logic [15:0] OFF_WORK = 16'h0040;
    localparam logic [15:0] OFF_DMEM = 16'h4000;
    localparam int STAT_TAKEN_BIT = 8;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0002;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [15:0] WORK_RST = 16'h0000;
    localparam int BRANCH_CYC = 1;
    localparam int BRANCH_TAKEN_CYC = 2;
    // instruction field positions (lsb of each field)
    localparam int F_OP = 19;
    localparam int F_BASE = 15;
    localparam int F_COND = 15;
    localparam int F_BYTE = 14;
    localparam int F_TOWREG = 13;
    localparam int F_BITSEL = 13;
    localparam int F_DMODE = 11;
    localparam int F_DREG = 7;
    localparam int F_SMODE = 4;
    localparam int F_MEDIUM_IMMEDIATE = 4;
    localparam int F_DVD = 4;
    localparam int F_SREG = 0;
    typedef struct packed {
        logic c;
        logic hc;
        logic n;
        logic sv;
        logic z;
    } casb_flags_t;
    typedef enum logic [4:0] {
        OP_ADD_F = 5'h00, OP_ADD_K10 = 5'h01, OP_ADD_W = 5'h02,
        OP_ADD_K5 = 5'h03, OP_ADCY_F = 5'h04, OP_ADCY_K10 = 5'h05,
        OP_ADCY_W = 5'h06, OP_ADCY_K5 = 5'h07, OP_AND_F = 5'h08,
        OP_AND_K10 = 5'h09, OP_AND_W = 5'h0A, OP_AND_K5 = 5'h0B,
        OP_SRA_F = 5'h0C, OP_SRA_W = 5'h0D, OP_SRA_R = 5'h0E,
        OP_SRA_K = 5'h0F, OP_BZERO_F = 5'h10, OP_BZERO_W = 5'h11,
        OP_BRANCH = 5'h12, OP_DIV = 5'h13
    } casb_op_t;
    typedef enum logic [2:0] {
        AM_DIR = 3'h0, AM_IND = 3'h1, AM_PDEC = 3'h2, AM_PINC = 3'h3,
        AM_DECP = 3'h4, AM_INCP = 3'h5, AM_BOFF = 3'h6
    } casb_am_t;
    typedef enum logic [3:0] {
        CC_SV = 4'h0, CC_C = 4'h1, CC_Z = 4'h2, CC_N = 4'h3,
        CC_SLE = 4'h4, CC_LT = 4'h5, CC_LEU = 4'h6, CC_AL = 4'h7,
        CC_NOV = 4'h8, CC_NC = 4'h9, CC_NZ = 4'hA, CC_NN = 4'hB,
        CC_GT = 4'hC, CC_GE = 4'hD, CC_GTU = 4'hE
    } casb_cond_t;
endpackage

// ===== casb_core.sv
// Purpose: execution subset core, instructions issued over Avalon-MM
// Assumes: clk_i 25 MHz, srst_i synchronous active high, ce_i freezes all but srst_i
// Notes: a write to the instruction register executes that word
// Overview of operation
// RULE1: bit selector is 4 bits, 0..15
// RULE2: five flags kept; carry-add zero is sticky
// RULE3: file forms use W0 implicitly
// RULE4: sixteen working registers, 4-bit numbers
// RULE5: file address is 13 bits direct
// RULE6: medium literal 0..255 byte, 0..1023 word
// RULE7: short literal 5 bits, zero-extended
// RULE8: word size unless byte qualifier encoded
// RULE9: base plus literal plus carry, one cycle
// RULE10: file carry-add may land in W0
// RULE11: single arithmetic shift keeps sign, sets flags
// RULE12: file shift result to file or W0
// RULE13: barrel shift by register, N Z only
// RULE14: barrel shift by literal, N Z only
// RULE15: branch one word, 1 or 2 cycles
// RULE16: signed conditions from sign, overflow, zero
// RULE17: divide pair read directly from registers
// RULE18: source direct, indirect, modified, base-offset modes
// RULE19: destination direct, indirect, pre/post modify modes
// RULE20: plain add, no carry-in, all flags
// RULE21: AND touches only N and Z
// RULE22: 24-bit word, 8-bit opcode field; the code decodes a 5-bit opcode from bits 23:19
`timescale 1ns/1ns
module casb_core #(
    parameter int DM_AW = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output casb_pkg::casb_flags_t flags_o,
    output logic [15:0] pc_o
);
    logic [15:0] wfile [16];
    logic [15:0] dmem [2**DM_AW];
    logic [23:0] instr;
    logic taken_q;
    logic [1:0] stall;

    function automatic logic top_bit(input logic [15:0] v, input logic b);
        return b ? v[7] : v[15];
    endfunction

    function automatic logic is_zero(input logic [15:0] v, input logic b);
        return b ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction

    function automatic logic [15:0] be_merge(input logic [15:0] old,
            input logic [15:0] nw, input logic [1:0] be);
        return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // effective address of an indirect operand
    function automatic logic [15:0] ea_of(input casb_pkg::casb_am_t m,
            input logic [15:0] v, input logic [15:0] off,
            input logic [15:0] st);
        case (m)
            casb_pkg::AM_DECP: return v - st;
            casb_pkg::AM_INCP: return v + st;
            casb_pkg::AM_BOFF: return v + off;
            default: return v;
        endcase
    endfunction

    // pointer value after the access
    function automatic logic [15:0] ptr_of(input casb_pkg::casb_am_t m,
            input logic [15:0] v, input logic [15:0] st);
        case (m)
            casb_pkg::AM_PDEC, casb_pkg::AM_DECP: return v - st;
            casb_pkg::AM_PINC, casb_pkg::AM_INCP: return v + st;
            default: return v;
        endcase
    endfunction

    function automatic logic [15:0] mrd(input logic [15:0] a,
            input logic b);
        logic [15:0] w;
        w = dmem[a[DM_AW:1]];
        return b ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    endfunction

    function automatic logic cond_true(input logic [3:0] cc,
            input casb_pkg::casb_flags_t f);
        case (casb_pkg::casb_cond_t'(cc))
            casb_pkg::CC_SV: return f.sv;
            casb_pkg::CC_C: return f.c;
            casb_pkg::CC_Z: return f.z;
            casb_pkg::CC_N: return f.n;
            casb_pkg::CC_SLE: return f.z | (f.n ^ f.sv); // RULE16
            casb_pkg::CC_LT: return f.n ^ f.sv; // RULE16
            casb_pkg::CC_LEU: return ~f.c | f.z;
            casb_pkg::CC_AL: return 1'b1;
            casb_pkg::CC_NOV: return ~f.sv;
            casb_pkg::CC_NC: return ~f.c;
            casb_pkg::CC_NZ: return ~f.z;
            casb_pkg::CC_NN: return ~f.n;
            casb_pkg::CC_GT: return ~f.z & ~(f.n ^ f.sv); // RULE16
            casb_pkg::CC_GE: return ~(f.n ^ f.sv); // RULE16
            casb_pkg::CC_GTU: return f.c & ~f.z;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic is_w(input logic [15:0] a);
        return a[15:6] == casb_pkg::OFF_WORK[15:6];
    endfunction

    function automatic logic is_m(input logic [15:0] a);
        return a[15:14] == casb_pkg::OFF_DMEM[15:14];
    endfunction

    // instruction field decode
    logic [23:0] iw;
    casb_pkg::casb_op_t op;
    logic [2:0] cls;
    logic [1:0] form;
    logic byte_m;
    logic [3:0] base_r, dreg_r, sreg_r, bit_selector;
    logic [12:0] faddr;
    casb_pkg::casb_am_t smode, dmode;
    assign iw = avs_writedata_i[23:0];
    assign op = casb_pkg::casb_op_t'(iw[23:19]); // RULE22
    assign cls = op[4:2];
    assign form = op[1:0];
    assign base_r = iw[casb_pkg::F_BASE +: 4]; // RULE4
    assign dreg_r = iw[casb_pkg::F_DREG +: 4];
    assign sreg_r = iw[casb_pkg::F_SREG +: 4];
    assign bit_selector = iw[casb_pkg::F_BITSEL +: 4]; // RULE1
    assign faddr = iw[12:0]; // RULE5
    assign smode = casb_pkg::casb_am_t'(iw[casb_pkg::F_SMODE +: 3]);
    assign dmode = casb_pkg::casb_am_t'(iw[casb_pkg::F_DMODE +: 3]);
    // byte qualifier only exists on add, carry add, and, single shift
    assign byte_m = iw[casb_pkg::F_BYTE] & (cls < 3'h4)
        & ~(cls == 3'h3 && form[1]); // RULE8

    // bus handshake decode
    logic req, accept, bwr, go;
    assign req = avs_read_i | avs_write_i;
    assign accept = ce_i & req & avs_waitrequest_o & (stall == 2'h0);
    assign bwr = accept & avs_write_i;
    assign go = bwr & (avs_address_i == casb_pkg::OFF_INSTR);

    // execution datapath
    localparam logic [2:0] DK_NONE = 3'h0;
    localparam logic [2:0] DK_F = 3'h1;
    localparam logic [2:0] DK_D = 3'h2;
    localparam logic [2:0] DK_N = 3'h3;
    localparam logic [2:0] DK_WN = 3'h4;
    localparam logic [2:0] DK_S = 3'h5;
    logic [15:0] step, base_v, s_ea, s_v, d_ea, f_v, a, b, ax, bx, res;
    logic [16:0] sum;
    logic [4:0] amt;
    logic [2:0] dk;
    logic cin, taken, sp_en, dp_en, w_en, m_en;
    logic [3:0] w_idx, dp_idx;
    logic [15:0] w_v, dp_v, sp_v, m_a;
    logic [1:0] m_be;
    casb_pkg::casb_flags_t nf;

    always_comb begin
        step = byte_m ? 16'h0001 : 16'h0002;
        base_v = wfile[base_r];
        s_ea = ea_of(smode, wfile[sreg_r], base_v, step); // RULE18
        s_v = (smode == casb_pkg::AM_DIR) ? wfile[sreg_r]
            : mrd(s_ea, byte_m);
        d_ea = ea_of(dmode, wfile[dreg_r], base_v, step); // RULE19
        f_v = mrd({3'h0, faddr}, byte_m);
        a = base_v;
        b = s_v;
        amt = 5'h00;
        cin = 1'b0;
        dk = DK_D;
        taken = 1'b0;
        sp_en = 1'b0;
        case (form)
            2'h0: begin
                a = f_v;
                b = byte_m ? {8'h00, wfile[0][7:0]} : wfile[0]; // RULE3
                dk = DK_F;
            end
            2'h1: begin
                a = wfile[sreg_r];
                b = byte_m ? {8'h00, iw[casb_pkg::F_MEDIUM_IMMEDIATE +: 8]}
                    : {6'h00, iw[casb_pkg::F_MEDIUM_IMMEDIATE +: 10]}; // RULE6
                dk = DK_WN;
            end
            2'h2: sp_en = (smode != casb_pkg::AM_DIR);
            default: b = {11'h000, iw[4:0]}; // RULE7
        endcase
        ax = byte_m ? {8'h00, a[7:0]} : a;
        bx = byte_m ? {8'h00, b[7:0]} : b;
        if (cls == 3'h1) begin
            cin = flags_o.c; // RULE9
        end
        sum = {1'b0, ax} + {1'b0, bx} + {16'h0000, cin}; // RULE20
        res = sum[15:0];
        nf = flags_o;
        unique case (cls)
            3'h0, 3'h1: begin
                nf.c = byte_m ? sum[8] : sum[16];
                nf.hc = byte_m ? (sum[4] ^ ax[4] ^ bx[4])
                    : (sum[8] ^ ax[8] ^ bx[8]);
                nf.sv = (top_bit(ax, byte_m) == top_bit(bx, byte_m))
                    & (top_bit(sum[15:0], byte_m) != top_bit(ax, byte_m));
                nf.n = top_bit(sum[15:0], byte_m);
                // sticky zero: carry-add can only clear it
                nf.z = is_zero(sum[15:0], byte_m)
                    & ((cls == 3'h0) | flags_o.z); // RULE2
            end
            3'h2: begin
                res = a & b;
                nf.n = top_bit(res, byte_m); // RULE21
                nf.z = is_zero(res, byte_m); // RULE21
            end
            3'h3: begin
                if (form == 2'h1) begin
                    a = s_v;
                    sp_en = (smode != casb_pkg::AM_DIR);
                end
                if (!form[1]) begin
                    res = byte_m ? {8'h00, a[7], a[7:1]}
                        : {a[15], a[15:1]}; // RULE11
                    nf.c = a[0]; // RULE11
                    nf.sv = 1'b0;
                    dk = form[0] ? DK_D : DK_F; // RULE12
                end else begin
                    amt = form[0] ? iw[4:0]
                        : {1'b0, wfile[sreg_r][3:0]}; // RULE13 RULE14
                    res = 16'($signed(base_v) >>> amt);
                    dk = DK_N;
                end
                nf.n = top_bit(res, byte_m);
                nf.z = is_zero(res, byte_m);
            end
            3'h4: begin
                if (form == 2'h0) begin
                    res = f_v & ~(16'h0001 << bit_selector); // RULE1
                    dk = DK_F;
                end else if (form == 2'h1) begin
                    res = s_v & ~(16'h0001 << bit_selector);
                    dk = DK_S;
                    sp_en = (smode != casb_pkg::AM_DIR);
                end else if (form == 2'h2) begin
                    // branch leaves every flag alone
                    taken = cond_true(iw[casb_pkg::F_COND +: 4],
                        flags_o); // RULE15
                    dk = DK_NONE;
                end else begin
                    // divide pair is always direct, no modes
                    a = wfile[iw[casb_pkg::F_DVD +: 4]]; // RULE17
                    b = wfile[sreg_r]; // RULE17
                    res = (b == 16'h0000) ? 16'hFFFF : a / b;
                    dk = DK_NONE;
                end
            end
            default: dk = DK_NONE;
        endcase
        sp_v = ptr_of(smode, wfile[sreg_r], step);
        dp_en = 1'b0;
        dp_idx = dreg_r;
        dp_v = ptr_of(dmode, wfile[dreg_r], step);
        w_en = 1'b0;
        w_idx = dreg_r;
        m_en = 1'b0;
        m_a = d_ea;
        case (dk)
            DK_F: begin
                if (iw[casb_pkg::F_TOWREG]) begin
                    w_en = 1'b1; // RULE10
                    w_idx = 4'h0;
                end else begin
                    m_en = 1'b1;
                    m_a = {3'h0, faddr};
                end
            end
            DK_D: begin
                w_en = (dmode == casb_pkg::AM_DIR);
                m_en = ~w_en;
                dp_en = ~w_en;
            end
            DK_N: w_en = 1'b1;
            DK_WN: begin
                w_en = 1'b1;
                w_idx = sreg_r;
            end
            DK_S: begin
                w_en = (smode == casb_pkg::AM_DIR);
                m_en = ~w_en;
                m_a = s_ea;
            end
            default: begin
                if (cls == 3'h4 && form == 2'h3) begin
                    w_en = 1'b1;
                    w_idx = 4'h0;
                    dp_en = 1'b1;
                    dp_idx = 4'h1;
                    dp_v = (b == 16'h0000) ? a : a % b;
                end
            end
        endcase
        w_v = be_merge(wfile[w_idx], res, byte_m ? 2'h1 : 2'h3);
        m_be = byte_m ? (m_a[0] ? 2'h2 : 2'h1) : 2'h3;
    end

    // working register array
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 16; i++) begin
                wfile[i] <= casb_pkg::WORK_RST;
            end
        end else if (ce_i) begin
            if (bwr && is_w(avs_address_i)) begin
                wfile[avs_address_i[5:2]] <= be_merge(
                    wfile[avs_address_i[5:2]], avs_writedata_i[15:0],
                    avs_byteenable_i[1:0]);
            end
            if (go) begin
                // pointer updates first, result overrides them
                if (sp_en) begin
                    wfile[sreg_r] <= sp_v; // RULE18
                end
                if (dp_en) begin
                    wfile[dp_idx] <= dp_v; // RULE19
                end
                if (w_en) begin
                    wfile[w_idx] <= w_v;
                end
            end
        end
    end

    // data space, word array, byte lanes
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (bwr && is_m(avs_address_i)) begin
                if (avs_byteenable_i[0]) begin
                    dmem[avs_address_i[DM_AW+1:2]][7:0] <=
                        avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    dmem[avs_address_i[DM_AW+1:2]][15:8] <=
                        avs_writedata_i[15:8];
                end
            end else if (go && m_en) begin
                if (m_be[0]) begin
                    dmem[m_a[DM_AW:1]][7:0] <= res[7:0];
                end
                if (m_be[1]) begin
                    dmem[m_a[DM_AW:1]][15:8] <= byte_m ? res[7:0]
                        : res[15:8];
                end
            end
        end
    end

    // status flags and branch record
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flags_o <= casb_pkg::FLAGS_RST;
            taken_q <= 1'b0;
        end else if (ce_i) begin
            if (go) begin
                flags_o <= nf;
                taken_q <= taken;
            end else if (bwr && avs_address_i == casb_pkg::OFF_STATUS
                    && avs_byteenable_i[0]) begin
                flags_o <= avs_writedata_i[4:0];
            end
        end
    end

    // program counter, byte address, steps by two
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pc_o <= casb_pkg::PC_RST;
            instr <= 24'h000000;
        end else if (ce_i) begin
            if (go) begin
                instr <= iw;
                pc_o <= pc_o + casb_pkg::PC_STEP
                    + (taken ? {iw[14:0], 1'b0} : 16'h0000); // RULE15
            end else if (bwr && avs_address_i == casb_pkg::OFF_PC) begin
                pc_o <= be_merge(pc_o, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0]);
            end
        end
    end

    logic [31:0] rd;
    always_comb begin
        rd = 32'h00000000;
        if (avs_address_i == casb_pkg::OFF_INSTR) begin
            rd = {8'h00, instr};
        end else if (avs_address_i == casb_pkg::OFF_STATUS) begin
            rd[4:0] = flags_o;
            rd[casb_pkg::STAT_TAKEN_BIT] = taken_q;
        end else if (avs_address_i == casb_pkg::OFF_PC) begin
            rd = {16'h0000, pc_o};
        end else if (is_w(avs_address_i)) begin
            rd = {16'h0000, wfile[avs_address_i[5:2]]};
        end else if (is_m(avs_address_i)) begin
            rd = {16'h0000, dmem[avs_address_i[DM_AW+1:2]]};
        end
    end

    // waitrequest idles high; a taken branch holds it one cycle more
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
            stall <= 2'h0;
            avs_readdata_o <= 32'h00000000;
        end else if (ce_i) begin
            if (!avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b1;
            end else if (stall != 2'h0) begin
                stall <= stall - 2'h1;
                if (stall == 2'h1) begin
                    avs_waitrequest_o <= 1'b0;
                end
            end else if (req) begin
                if (avs_read_i) begin
                    avs_readdata_o <= rd;
                end
                if (go && taken) begin
                    stall <= 2'(casb_pkg::BRANCH_TAKEN_CYC
                        - casb_pkg::BRANCH_CYC); // RULE15
                end else begin
                    avs_waitrequest_o <= 1'b0;
                end
            end
        end
    end

    // checks
    logic [15:0] chk_k5, chk_f;
    assign chk_k5 = wfile[base_r] + {11'h000, iw[4:0]}
        + {15'h0000, flags_o.c};
    assign chk_f = dmem[faddr[DM_AW:1]] + wfile[0] + {15'h0000, flags_o.c};

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    zero_sticky_a: assert property ( // RULE2
        go && cls == 3'h1 && !flags_o.z |=> !flags_o.z)
        else $error("sticky zero was set by carry add");
    sum_with_carry_in_lit_a: assert property ( // RULE9
        go && op == casb_pkg::OP_ADCY_K5 && dmode == casb_pkg::AM_DIR
        && !byte_m |=> wfile[$past(dreg_r)] == $past(chk_k5))
        else $error("carry add with literal gave wrong sum");
    sum_with_carry_in_implicit_accumulator_a: assert property ( // RULE10
        go && op == casb_pkg::OP_ADCY_F && iw[casb_pkg::F_TOWREG]
        && !byte_m |=> wfile[0] == $past(chk_f))
        else $error("file carry add did not land in W0");
    and_flags_a: assert property ( // RULE21
        go && cls == 3'h2 |=> $stable(flags_o.c) && $stable(flags_o.hc)
        && $stable(flags_o.sv))
        else $error("logical and touched carry or overflow flags");
    asr_sign_a: assert property ( // RULE11
        go && op == casb_pkg::OP_SRA_W && smode == casb_pkg::AM_DIR
        && dmode == casb_pkg::AM_DIR && !byte_m
        |=> wfile[$past(dreg_r)] == {$past(s_v[15]), $past(s_v[15:1])}
        && flags_o.c == $past(s_v[0]) && !flags_o.sv)
        else $error("single arithmetic shift wrong");
    barrel_keep_a: assert property ( // RULE13 RULE14
        go && cls == 3'h3 && form[1] |=> $stable(flags_o.c)
        && $stable(flags_o.hc) && $stable(flags_o.sv))
        else $error("barrel shift touched carry or overflow flags");
    bra_taken_a: assert property ( // RULE15
        ce_i && go && op == casb_pkg::OP_BRANCH && taken
        |=> avs_waitrequest_o ##1 !avs_waitrequest_o && $stable(flags_o))
        else $error("taken branch not two cycles");
    bra_fall_a: assert property ( // RULE15
        ce_i && go && op == casb_pkg::OP_BRANCH && !taken
        |=> !avs_waitrequest_o && $stable(flags_o)
        && pc_o == $past(pc_o) + casb_pkg::PC_STEP)
        else $error("untaken branch not one cycle");
    signed_gt_a: assert property ( // RULE16
        go && op == casb_pkg::OP_BRANCH
        && iw[casb_pkg::F_COND +: 4] == casb_pkg::CC_GT
        && (flags_o.z || flags_o.n != flags_o.sv)
        |=> pc_o == $past(pc_o) + casb_pkg::PC_STEP)
        else $error("signed greater branch taken wrongly");

    sum_with_carry_in_run_c: cover property (go && cls == 3'h1 && form == 2'h3);
    bra_taken_c: cover property (go && op == casb_pkg::OP_BRANCH && taken);
    bra_fall_c: cover property (go && op == casb_pkg::OP_BRANCH && !taken);
    barrel_c: cover property (go && op == casb_pkg::OP_SRA_R);
endmodule

// ===== casb_core_test.sv
// Purpose: self-checking bench for the execution subset core
// Assumes: register map and instruction encoding of casb_pkg
// Notes: fixed-seed random operands, corner values in the first passes
`timescale 1ns/1ns
module casb_core_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic waitreq;
    casb_pkg::casb_flags_t flags;
    logic [15:0] pc;
    int num_errors = 0;
    int compares = 0;
    int seed = 32'hBDF7;
    int i, k, c, n;
    logic [15:0] a, b, epc;
    logic [4:0] fi, x;
    logic [4:0] ops [6] = '{5'h02, 5'h07, 5'h09, 5'h0D, 5'h0F, 5'h0E};
    logic [23:0] iw;
    logic [20:0] e;
    logic [14:0] off;
    logic [31:0] q;
    logic t;

    casb_core u_dut (.clk_i(clk), .srst_i(srst), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq),
        .flags_o(flags), .pc_o(pc));

    initial begin
        forever #20 clk = ~clk;
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // held until waitrequest is seen low; n counts edges from launch
    task bus(input logic w, input logic [15:0] ad, input logic [31:0] d);
        @(posedge clk);
        adr <= ad;
        wdat <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // flags packed {c,hc,n,sv,z}; result in the upper 16 bits
    function automatic logic [20:0] model(int k, logic [15:0] a,
        logic [15:0] b, logic [4:0] fi);
        logic [16:0] s;
        logic [8:0] h;
        logic [15:0] r;
        logic [4:0] f;
        logic ci;
        f = fi;
        ci = (k == 1) ? fi[4] : 1'b0;
        s = a + b + ci;
        h = a[7:0] + b[7:0] + ci;
        case (k)
            0, 1: begin
                r = s[15:0];
                f[4] = s[16];
                f[3] = h[8];
                f[1] = (a[15] == b[15]) && (r[15] != a[15]);
            end
            2: r = a & b;
            3: begin
                r = {a[15], a[15:1]};
                f[4] = a[0];
                f[1] = 1'b0;
            end
            default: r = $signed(a) >>> b[4:0];
        endcase
        f[2] = r[15];
        f[0] = (r == 16'h0000) && (k != 1 || fi[0]);
        return {r, f};
    endfunction

    // conditions 8..F are the inverses of 0..7
    function automatic logic taken(logic [3:0] c, logic [4:0] f);
        logic [7:0] tb;
        tb = {1'b1, !f[4] | f[0], f[2] ^ f[1], f[0] | (f[2] ^ f[1]),
            f[2], f[0], f[4], f[1]};
        return tb[c[2:0]] ^ c[3];
    endfunction

    task finish_test;
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        finish_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check({11'h000, flags}, 16'h0000);
        epc = 16'h0000;
        for (i = 0; i < 40; i++) begin
            for (k = 0; k < 6; k++) begin
                a = 16'($random(seed));
                b = 16'($random(seed));
                fi = 5'($random(seed));
                // signed overflow, sign shift, widest literal shift
                if (i == 0) begin
                    a = 16'h7FFF;
                    b = 16'h0001;
                    fi = 5'h01;
                end
                if (i == 1) begin
                    a = 16'h8000;
                    b = 16'hFFFF;
                    fi = 5'h10;
                end
                if (k == 1 || k == 4) b = b & 16'h001F;
                if (k == 2) b = b & 16'h03FF;
                if (k == 5) b = b & 16'h000F;
                x = (k == 0 || k == 5) ? 5'h02 : (k == 3) ? 5'h01 : b[4:0];
                iw = (k == 2) ? {5'h09, 5'h00, b[9:0], 4'h1}
                    : {ops[k], 4'h1, 1'b0, 3'h0, 4'h3, 2'h0, x};
                bus(1'b1, 16'h0044, {16'h0000, a});
                bus(1'b1, 16'h0048, {16'h0000, b});
                bus(1'b1, 16'h004C, {16'h0000, ~a});
                bus(1'b1, 16'h0004, {27'h0000000, fi});
                bus(1'b1, 16'h0000, {8'h00, iw});
                check(n[15:0], 16'h0002);
                epc = epc + 16'h0002;
                check(pc, epc);
                e = model(k, a, b, fi);
                bus(1'b0, (k == 2) ? 16'h0044 : 16'h004C, 32'h00000000);
                check(q[15:0], e[20:5]);
                check({11'h000, flags}, {11'h000, e[4:0]});
            end
        end
        for (c = 0; c < 32; c++) begin
            fi = 5'($random(seed));
            off = 15'($random(seed));
            bus(1'b1, 16'h0004, {27'h0000000, fi});
            bus(1'b1, 16'h0000, {8'h00, 5'h12, c[3:0], off});
            t = taken(c[3:0], fi);
            check(n[15:0], t ? 16'h0003 : 16'h0002);
            epc = epc + 16'h0002 + (t ? {off, 1'b0} : 16'h0000);
            check(pc, epc);
            check({11'h000, flags}, {11'h000, fi});
        end
        bus(1'b0, 16'h0100, 32'h00000000);
        check(q[15:0], 16'h0000);
        finish_test;
    end
endmodule
